// File: rtl/alarm_map.svh
`ifndef ALARM_MAP_SVH
`define ALARM_MAP_SVH

// ==========================================================
// Timing
`define CLK_PERIOD_NS       10
`define TICK_NS             1000000
`define TICK_CYCLES         (`TICK_NS / `CLK_PERIOD_NS)
`define LINK_TIMEOUT_S      5
`define LINK_TIMEOUT_TICKS  (`LINK_TIMEOUT_S * 1000)

// ==========================================================
// Ambient bands, degrees F
`define TEMP_WARN_LO_MIN    23
`define TEMP_WARN_LO_MAX    32
`define TEMP_WARN_HI_MIN    122
`define TEMP_WARN_HI_MAX    131

// ==========================================================
// Register byte offsets
`define OFS_CTRL            8'h00
`define OFS_OVERRIDE        8'h04
`define OFS_LOOP_MODE       8'h08
`define OFS_STATUS          8'h0c
`define OFS_IRQ_STATUS      8'h10
`define OFS_IRQ_CLEAR       8'h14
`define OFS_IRQ_ENABLE      8'h18
`define OFS_TEMP            8'h1c

// CTRL fields
`define CTRL_MON_EN         0
`define CTRL_ACK            1
`define CTRL_FAIL_DO_EN     2

// Alarm / status bit positions
`define AL_LINK             0
`define AL_WARN             1
`define AL_AMB_FAIL         2
`define AL_BATT             3
`define ST_LINK_UP          4

// Interrupt event bit positions
`define EV_LINK_LOST        0
`define EV_WARN             1
`define EV_AMB_FAIL         2
`define EV_BATT             3
`define EV_LINK_BACK        4

// ==========================================================
// Reset and factory values
`define CTRL_RESET          3'h1
`define OVERRIDE_DEFAULT    7'h00
`define NUM_LOOPS           8
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// File: rtl/alarm_pkg.sv
`default_nettype none
package alarm_pkg;
    typedef enum logic [1:0] {
        WD_WAIT  = 2'b00,
        WD_WATCH = 2'b01,
        WD_FAIL  = 2'b10
    } wd_state_t;

    typedef logic        [6:0] pct_t;
    typedef logic signed [9:0] temp_t;
endpackage
`default_nettype wire

// File: rtl/link_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
`include "alarm_map.svh"

module link_watchdog #(
    parameter int unsigned TICK_CYCLES   = `TICK_CYCLES,
    parameter int unsigned TIMEOUT_TICKS = `LINK_TIMEOUT_TICKS
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Monitor
    input  wire logic enable,
    input  wire logic activity,
    output logic      link_fail,
    output logic      link_up
);
    alarm_pkg::wd_state_t state_r, state_nxt;
    logic [31:0]          div_r, div_nxt;
    logic [31:0]          age_r, age_nxt;
    logic                 tick;

    // ==========================================================
    // Slow time base and silence timer
    always_comb begin
        tick    = 1'b0;
        div_nxt = div_r + 32'h1;
        if (div_r >= TICK_CYCLES - 1) begin
            div_nxt = 32'h0;
            tick    = 1'b1;
        end
        state_nxt = state_r;
        age_nxt   = age_r;
        unique case (state_r)
            alarm_pkg::WD_WAIT: begin
                // Nothing is watched until the link has spoken once
                if (activity) begin
                    state_nxt = alarm_pkg::WD_WATCH;
                    age_nxt   = 32'h0;
                end
            end
            alarm_pkg::WD_WATCH: begin
                if (activity) begin
                    age_nxt = 32'h0;
                end else if (tick) begin
                    if (age_r >= TIMEOUT_TICKS) begin
                        state_nxt = alarm_pkg::WD_FAIL; // [R01]
                    end else begin
                        age_nxt = age_r + 32'h1;
                    end
                end
            end
            alarm_pkg::WD_FAIL: begin
                if (activity) begin
                    state_nxt = alarm_pkg::WD_WATCH;
                    age_nxt   = 32'h0;
                end
            end
            default: state_nxt = alarm_pkg::WD_WAIT;
        endcase
        if (!enable) begin
            state_nxt = alarm_pkg::WD_WAIT;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r   <= alarm_pkg::WD_WAIT;
            div_r     <= 32'h0;
            age_r     <= 32'h0;
            link_fail <= 1'b0;
            link_up   <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            div_r     <= div_nxt;
            age_r     <= age_nxt;
            link_fail <= (state_nxt == alarm_pkg::WD_FAIL);
            link_up   <= (state_nxt == alarm_pkg::WD_WATCH);
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_timeout_fire: assert property (enable && !activity && tick &&        // [R01]
        state_r == alarm_pkg::WD_WATCH && age_r >= TIMEOUT_TICKS |=> link_fail)
        else $error("link failure not declared after silence");
    a_no_early_fail: assert property ($rose(link_fail) |->                 // [R01]
        $past(age_r) >= TIMEOUT_TICKS)
        else $error("link failure declared too early");
endmodule
`default_nettype wire

// File: rtl/ambient_classifier.sv
`timescale 1ns/1ps
`default_nettype none
`include "alarm_map.svh"

module ambient_classifier (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // Temperature in, degrees F
    input  wire alarm_pkg::temp_t temp,
    // Band flags
    output logic                  warn,
    output logic                  fail
);
    logic warn_nxt;
    logic fail_nxt;

    function automatic logic in_band(alarm_pkg::temp_t t, int lo, int hi);
        return (int'(t) >= lo) && (int'(t) <= hi);
    endfunction

    // ==========================================================
    // Band decode
    always_comb begin
        warn_nxt = in_band(temp, `TEMP_WARN_LO_MIN, `TEMP_WARN_LO_MAX)
                 | in_band(temp, `TEMP_WARN_HI_MIN, `TEMP_WARN_HI_MAX); // [R07]
        // More than nine degrees beyond the operating band
        fail_nxt = !in_band(temp, `TEMP_WARN_LO_MIN, `TEMP_WARN_HI_MAX); // [R08]
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            warn <= 1'b0;
            fail <= 1'b0;
        end else begin
            warn <= warn_nxt;
            fail <= fail_nxt;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_warn_band: assert property (int'(temp) >= 122 && int'(temp) <= 131 |=> warn) // [R07]
        else $error("warning band missed");
    a_fail_band: assert property (int'(temp) > 131 || int'(temp) < 23 |=> fail && !warn) // [R08]
        else $error("failure band missed");
endmodule
`default_nettype wire

// File: rtl/alarm_link_supervisor.sv
//Contract
//R01: Declare link failure after over five seconds silence
//R02: Link failure forces every loop to manual
//R03: Link failure drives outputs to override percentage
//R04: Link failure asserts the global alarm
//R05: Selected digital output follows link failure
//R06: Loops stay manual until per-loop command
//R07: Warning flag in 23-32 or 122-131 F
//R08: Failure alarm beyond band by over 9 F
//R09: Ambient alarms clear when in range and acknowledged
//R10: Weak battery raises alarm, parameters take defaults
//R11: Alarms latch until acknowledge, then follow cause
`timescale 1ns/1ps
`default_nettype none
`include "alarm_map.svh"

module alarm_link_supervisor #(
    parameter int unsigned TICK_CYCLES   = `TICK_CYCLES,
    parameter int unsigned TIMEOUT_TICKS = `LINK_TIMEOUT_TICKS
) (
    // Clock and reset
    input  wire logic                         sys_clk,
    input  wire logic                         rst,
    // AXI4-Lite write
    input  wire logic [7:0]                   s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]                   s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    // Input module link and sensors
    input  wire logic                         link_activity,
    input  wire alarm_pkg::temp_t             ambient_temp,
    input  wire logic                         battery_weak,
    // Loop control
    input  wire logic [`NUM_LOOPS*7-1:0]      pid_out_pct,
    output logic [`NUM_LOOPS-1:0]             loop_manual,
    output logic [`NUM_LOOPS*7-1:0]           ctrl_out_pct,
    // Alarms
    output logic                              global_alarm,
    output logic                              link_fail_alarm,
    output logic                              link_fail_do,
    output logic                              ambient_warning_flag,
    output logic                              ambient_fail_alarm,
    output logic                              battery_dead_alarm,
    output logic                              irq
);
    localparam int NL = `NUM_LOOPS;

    // ==========================================================
    // Declarations
    logic                awready_r, awready_nxt, wready_r, wready_nxt;
    logic                adr_have_r, adr_have_nxt, w_have_r, w_have_nxt;
    logic [7:0]          waddr_r, waddr_nxt;
    logic [31:0]         wdata_r, wdata_nxt;
    logic                wstrb0_r, wstrb0_nxt;
    logic                bvalid_r, bvalid_nxt;
    logic [1:0]          bresp_r, bresp_nxt;
    logic                arready_r, arready_nxt, rvalid_r, rvalid_nxt;
    logic [31:0]         rdata_r, rdata_nxt;
    logic [1:0]          rresp_r, rresp_nxt;
    logic                wr_en;
    logic [7:0]          wr_addr;
    logic [31:0]         wr_data;

    logic [2:0]          ctrl_r, ctrl_nxt;
    alarm_pkg::pct_t     override_r, override_nxt;
    logic [NL-1:0]       manual_r, manual_nxt;
    logic [NL*7-1:0]     out_r, out_nxt;
    logic [3:0]          alarm_r, alarm_nxt, cause;
    logic                global_r, global_nxt, fail_do_r, fail_do_nxt;
    logic [4:0]          ev_stat_r, ev_stat_nxt, ev_en_r, ev_en_nxt, events;
    logic                irq_r, irq_nxt;
    logic                batt_m_r, batt_s_r, batt_d_r, link_d_r;
    logic                ack, mode_wr;
    logic                link_fail_w, link_up_w, amb_warn_w, amb_fail_w;

    // ==========================================================
    // Submodules
    link_watchdog #(
        .TICK_CYCLES   (TICK_CYCLES),
        .TIMEOUT_TICKS (TIMEOUT_TICKS)
    ) u_watchdog (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .enable    (ctrl_r[`CTRL_MON_EN]),
        .activity  (link_activity),
        .link_fail (link_fail_w),
        .link_up   (link_up_w)
    );

    ambient_classifier u_ambient (
        .sys_clk (sys_clk),
        .rst     (rst),
        .temp    (ambient_temp),
        .warn    (amb_warn_w),
        .fail    (amb_fail_w)
    );

    // ==========================================================
    // AXI4-Lite slave
    // Address and data may come in either order; one response each.
    always_comb begin
        adr_have_nxt = adr_have_r | (s_axi_awvalid & awready_r);
        w_have_nxt  = w_have_r | (s_axi_wvalid & wready_r);
        waddr_nxt   = (s_axi_awvalid & awready_r) ? s_axi_awaddr : waddr_r;
        wdata_nxt   = (s_axi_wvalid & wready_r) ? s_axi_wdata : wdata_r;
        wstrb0_nxt  = (s_axi_wvalid & wready_r) ? s_axi_wstrb[0] : wstrb0_r;
        bvalid_nxt  = bvalid_r & ~s_axi_bready;
        bresp_nxt   = bresp_r;
        wr_en       = 1'b0;
        wr_addr     = waddr_nxt;
        wr_data     = wdata_nxt;
        if (adr_have_nxt && w_have_nxt && !bvalid_r) begin
            adr_have_nxt = 1'b0;
            w_have_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            wr_en       = wstrb0_nxt;
            unique case (waddr_nxt)
                `OFS_CTRL, `OFS_OVERRIDE, `OFS_LOOP_MODE,
                `OFS_IRQ_CLEAR, `OFS_IRQ_ENABLE: bresp_nxt = `RESP_OKAY;
                default: begin
                    bresp_nxt = `RESP_SLVERR;
                    wr_en     = 1'b0;
                end
            endcase
        end
        awready_nxt = ~adr_have_nxt & ~bvalid_nxt;
        wready_nxt  = ~w_have_nxt & ~bvalid_nxt;

        rvalid_nxt = rvalid_r & ~s_axi_rready;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (s_axi_arvalid && arready_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = `RESP_OKAY;
            unique case (s_axi_araddr)
                `OFS_CTRL:       rdata_nxt = {29'h0, ctrl_r};
                `OFS_OVERRIDE:   rdata_nxt = {25'h0, override_r};
                `OFS_LOOP_MODE:  rdata_nxt = {{(32-NL){1'b0}}, manual_r};
                `OFS_STATUS:     rdata_nxt = {27'h0, link_up_w, alarm_r};
                `OFS_IRQ_STATUS: rdata_nxt = {27'h0, ev_stat_r};
                `OFS_IRQ_ENABLE: rdata_nxt = {27'h0, ev_en_r};
                `OFS_TEMP:       rdata_nxt = {{22{ambient_temp[9]}}, ambient_temp};
                default: begin
                    rdata_nxt = 32'h0;
                    rresp_nxt = `RESP_SLVERR;
                end
            endcase
        end
        arready_nxt = ~rvalid_nxt;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            adr_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            waddr_r   <= 8'h0;
            wdata_r   <= 32'h0;
            wstrb0_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0;
            rresp_r   <= `RESP_OKAY;
        end else begin
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            adr_have_r <= adr_have_nxt;
            w_have_r  <= w_have_nxt;
            waddr_r   <= waddr_nxt;
            wdata_r   <= wdata_nxt;
            wstrb0_r  <= wstrb0_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
        end
    end

    // ==========================================================
    // Battery pin synchroniser and link failure delay
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            batt_m_r <= 1'b0;
            batt_s_r <= 1'b0;
            batt_d_r <= 1'b0;
            link_d_r <= 1'b0;
        end else begin
            batt_m_r <= battery_weak;
            batt_s_r <= batt_m_r;
            batt_d_r <= batt_s_r;
            link_d_r <= link_fail_w;
        end
    end

    // ==========================================================
    // Supervisory state
    always_comb begin
        ack     = wr_en && wr_addr == `OFS_CTRL && wr_data[`CTRL_ACK];
        mode_wr = wr_en && wr_addr == `OFS_LOOP_MODE;

        ctrl_nxt     = ctrl_r;
        override_nxt = override_r;
        if (wr_en && wr_addr == `OFS_CTRL) begin
            ctrl_nxt = wr_data[2:0] & 3'h5;
        end
        if (wr_en && wr_addr == `OFS_OVERRIDE) begin
            override_nxt = wr_data[6:0];
        end
        // Settings are lost with the battery, so fall back to factory values
        if (batt_s_r && !batt_d_r) begin
            ctrl_nxt     = `CTRL_RESET;                                 // [R10]
            override_nxt = `OVERRIDE_DEFAULT;                           // [R10]
        end

        // Only an explicit mode write brings a loop back to automatic
        manual_nxt = mode_wr ? wr_data[NL-1:0] : manual_r;              // [R06]
        if (link_fail_w) begin
            manual_nxt = '1;                                            // [R02]
        end

        // Manual loops hold their last output instead of tracking the PID
        for (int i = 0; i < NL; i++) begin
            if (link_fail_w) begin
                out_nxt[i*7 +: 7] = override_r;                         // [R03]
            end else if (manual_r[i]) begin
                out_nxt[i*7 +: 7] = out_r[i*7 +: 7];
            end else begin
                out_nxt[i*7 +: 7] = pid_out_pct[i*7 +: 7];
            end
        end

        cause[`AL_LINK]     = link_fail_w;
        cause[`AL_WARN]     = amb_warn_w;                               // [R07]
        cause[`AL_AMB_FAIL] = amb_fail_w;                               // [R08]
        cause[`AL_BATT]     = batt_s_r;                                 // [R10]
        // A present cause always wins over the acknowledge
        alarm_nxt  = cause | (alarm_r & ~{4{ack}});                     // [R11] [R09]
        global_nxt = |alarm_nxt;                                        // [R04]
        fail_do_nxt = ctrl_r[`CTRL_FAIL_DO_EN] & link_fail_w;           // [R05]

        events[`EV_LINK_LOST] = link_fail_w & ~link_d_r;
        events[`EV_WARN]      = amb_warn_w & ~alarm_r[`AL_WARN];
        events[`EV_AMB_FAIL]  = amb_fail_w & ~alarm_r[`AL_AMB_FAIL];
        events[`EV_BATT]      = batt_s_r & ~batt_d_r;
        events[`EV_LINK_BACK] = ~link_fail_w & link_d_r;
        ev_en_nxt   = (wr_en && wr_addr == `OFS_IRQ_ENABLE) ? wr_data[4:0] : ev_en_r;
        ev_stat_nxt = ev_stat_r;
        if (wr_en && wr_addr == `OFS_IRQ_CLEAR) begin
            ev_stat_nxt = ev_stat_r & ~wr_data[4:0];
        end
        ev_stat_nxt = ev_stat_nxt | events;
        irq_nxt     = |(ev_stat_nxt & ev_en_nxt);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_r     <= `CTRL_RESET;
            override_r <= `OVERRIDE_DEFAULT;
            manual_r   <= '0;
            out_r      <= '0;
            alarm_r    <= 4'h0;
            global_r   <= 1'b0;
            fail_do_r  <= 1'b0;
            ev_stat_r  <= 5'h0;
            ev_en_r    <= 5'h0;
            irq_r      <= 1'b0;
        end else begin
            ctrl_r     <= ctrl_nxt;
            override_r <= override_nxt;
            manual_r   <= manual_nxt;
            out_r      <= out_nxt;
            alarm_r    <= alarm_nxt;
            global_r   <= global_nxt;
            fail_do_r  <= fail_do_nxt;
            ev_stat_r  <= ev_stat_nxt;
            ev_en_r    <= ev_en_nxt;
            irq_r      <= irq_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign s_axi_awready        = awready_r;
    assign s_axi_wready         = wready_r;
    assign s_axi_bvalid         = bvalid_r;
    assign s_axi_bresp          = bresp_r;
    assign s_axi_arready        = arready_r;
    assign s_axi_rvalid         = rvalid_r;
    assign s_axi_rdata          = rdata_r;
    assign s_axi_rresp          = rresp_r;
    assign loop_manual          = manual_r;
    assign ctrl_out_pct         = out_r;
    assign global_alarm         = global_r;
    assign link_fail_alarm      = alarm_r[`AL_LINK];
    assign link_fail_do         = fail_do_r;
    assign ambient_warning_flag = alarm_r[`AL_WARN];
    assign ambient_fail_alarm   = alarm_r[`AL_AMB_FAIL];
    assign battery_dead_alarm   = alarm_r[`AL_BATT];
    assign irq                  = irq_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_link_lost;
        $rose(link_fail_w);
    endsequence
    sequence s_forced;
        &manual_r ##0 global_r;
    endsequence

    a_fail_manual: assert property (s_link_lost |=> s_forced) // [R02]
        else $error("loops not forced to manual with alarm");
    a_fail_override: assert property (link_fail_w |=>                 // [R03]
        out_r[6:0] == $past(override_r) && out_r[NL*7-1 -: 7] == $past(override_r))
        else $error("outputs not at override value");
    a_fail_global: assert property (link_fail_w |=> global_r) // [R04]
        else $error("global alarm missing on link failure");
    a_fail_output: assert property (link_fail_w && ctrl_r[`CTRL_FAIL_DO_EN] |=> fail_do_r) // [R05]
        else $error("link failure output not driven");
    a_stay_manual: assert property ($fell(link_fail_w) && !mode_wr |=> &manual_r) // [R06]
        else $error("loop left manual without command");
    a_warn_flag: assert property (amb_warn_w |=> ambient_warning_flag) // [R07]
        else $error("ambient warning flag missing");
    a_amb_fail: assert property (amb_fail_w |=> ambient_fail_alarm) // [R08]
        else $error("ambient failure alarm missing");
    a_auto_clear: assert property (alarm_r[`AL_WARN] && !amb_warn_w && ack |=> // [R09]
        !ambient_warning_flag)
        else $error("warning not cleared after acknowledge");
    a_alarm_latch: assert property (alarm_r[`AL_AMB_FAIL] && !ack |=> // [R11]
        ambient_fail_alarm [*1])
        else $error("alarm dropped without acknowledge");
    a_batt_alarm: assert property ($rose(batt_s_r) |=>                // [R10]
        battery_dead_alarm && override_r == `OVERRIDE_DEFAULT)
        else $error("battery alarm or defaults missing");
endmodule
`default_nettype wire

// File: sim/link_partner.sv
`timescale 1ns/1ps
`default_nettype none

module link_partner (
    // Clock
    input  wire logic sys_clk,
    // Bench control
    input  wire logic talk,
    // Link traffic
    output logic      link_activity
);
    logic [1:0] cnt_r = 2'h0;

    initial link_activity = 1'b0;

    // Remote module answers every fourth cycle while talking
    always @(posedge sys_clk) begin
        cnt_r         <= cnt_r + 2'h1;
        link_activity <= talk && (cnt_r == 2'h0);
    end
endmodule

`default_nettype wire

// File: sim/alarm_link_supervisor_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "alarm_map.svh"

module alarm_link_supervisor_test;
    // ==========================================
    // Signals
    logic        sys_clk, rst, talk, battery_weak, link_activity, irq, global_alarm;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_bready, s_axi_rready;
    logic        link_fail_alarm, link_fail_do, ambient_warning_flag, ambient_fail_alarm;
    logic        battery_dead_alarm;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  s_axi_wstrb;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, loop_manual;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [55:0] pid_out_pct, ctrl_out_pct;
    alarm_pkg::temp_t ambient_temp;
    int          n_fail = 0, checks_done = 0, cyc = 0;

    // Short time base keeps the five second silence to about sixteen cycles
    alarm_link_supervisor #(.TICK_CYCLES(4), .TIMEOUT_TICKS(3)) alarm_link_supervisor_inst (
        .sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_activity, .ambient_temp,
        .battery_weak, .pid_out_pct, .loop_manual, .ctrl_out_pct, .global_alarm,
        .link_fail_alarm, .link_fail_do, .ambient_warning_flag, .ambient_fail_alarm,
        .battery_dead_alarm, .irq);
    link_partner link_partner_inst (.sys_clk, .talk, .link_activity);

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ==========================================
    // Helpers
    task automatic w(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic chk(input logic [55:0] got, input logic [55:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Ready lines drop after each handshake, so each valid is released once its ready is seen
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
    endtask

    // ==========================================
    // Scenarios
    task automatic link_test();
        wr(`OFS_OVERRIDE, 32'h2a);
        wr(`OFS_CTRL, 32'h5);
        wr(`OFS_IRQ_ENABLE, 32'h1f);
        talk <= 1'b1;
        w(20);
        talk <= 1'b0;
        w(8);
        chk(link_fail_alarm, 0);
        w(40);
        chk({global_alarm, link_fail_alarm, link_fail_do, irq}, 4'hf);
        chk(loop_manual, 8'hff);
        chk(ctrl_out_pct, {8{7'h2a}});
        rd(`OFS_STATUS, rv);
        chk(rv[4:0], 5'h01);
        talk <= 1'b1;
        w(10);
        wr(`OFS_CTRL, 32'h7);
        w(4);
        chk({link_fail_alarm, link_fail_do, loop_manual}, 10'h0ff);
        wr(`OFS_LOOP_MODE, 32'hfe);
        w(3);
        chk({loop_manual, ctrl_out_pct[6:0]}, {8'hfe, pid_out_pct[6:0]});
        wr(`OFS_IRQ_ENABLE, 32'h0);
        w(2);
        chk(irq, 0);
        rd(`OFS_IRQ_STATUS, rv);
        chk(rv[0], 1);
        wr(`OFS_IRQ_ENABLE, 32'h1f);
        w(2);
        chk(irq, 1);
        wr(`OFS_IRQ_CLEAR, 32'h1f);
        w(2);
        chk(irq, 0);
    endtask

    task automatic temp_test();
        alarm_pkg::temp_t t [4] = '{10'sd23, 10'sd131, 10'sd22, 10'sd132};
        for (int i = 0; i < 4; i++) begin
            ambient_temp <= t[i];
            w(4);
            chk({ambient_warning_flag, ambient_fail_alarm}, {i < 2, i >= 2});
            ambient_temp <= 10'sd70;
            w(4);
            chk(global_alarm, 1);
            wr(`OFS_CTRL, 32'h3);
            w(4);
            chk({ambient_warning_flag, ambient_fail_alarm}, 0);
        end
    endtask

    task automatic batt_test();
        battery_weak <= 1'b1;
        w(6);
        chk(battery_dead_alarm, 1);
        rd(`OFS_OVERRIDE, rv);
        chk(rv, 0);
        rd(`OFS_CTRL, rv);
        chk(rv, 1);
        battery_weak <= 1'b0;
        w(4);
        chk(battery_dead_alarm, 1);
        wr(`OFS_CTRL, 32'h3);
        w(4);
        chk(battery_dead_alarm, 0);
        rd(8'h40, rv);
        chk(rv, 0);
        chk(s_axi_rresp, 2'h2);
        wr(8'h40, 32'h0);
        chk(s_axi_bresp, 2'h2);
        rd(`OFS_TEMP, rv);
        chk(rv, 32'h46);
    endtask

    // ==========================================
    // Sequence and verdict
    task automatic final_report();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            final_report();
        end
    end

    initial begin
        {rst, talk, battery_weak, s_axi_bready, s_axi_rready} = 5'b10011;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb  = 4'hf;
        ambient_temp = 10'sd70;
        pid_out_pct  = 56'h0123456789abcd;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        w(2);
        link_test();
        temp_test();
        batt_test();
        final_report();
    end
endmodule

`default_nettype wire
